// ### hw/cst_core_state.sv
// Architectural state of the 8-bit core: stack, counter, registers, flags
`include "cst_defines.svh"
`default_nettype none

module cst_core_state (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             op_valid,
  output logic                  op_ready,
  input  wire cst_pkg::cst_op_t op_code,
  input  wire cst_pkg::cst_cc_t op_cc,
  input  wire logic [7:0]       op_disp,
  input  wire logic [15:0]      op_data,
  input  wire logic [15:0]      op_target,
  input  wire logic [2:0]       op_sel,
  input  wire logic [1:0]       op_len,
  output logic                  op_done_q,
  output logic                  branch_taken_q,
  output logic                  branch_fault_q,
  output logic                  div_error_q,
  input  wire logic             reg_we,
  input  wire logic             reg_byte,
  input  wire logic [2:0]       reg_idx,
  input  wire logic [15:0]      reg_wdata,
  input  wire logic             reg_rd_byte,
  input  wire logic [2:0]       reg_rd_idx,
  output logic [15:0]           reg_rdata_q,
  input  wire logic             flag_we,
  input  wire logic [7:0]       flag_wdata,
  input  wire logic             bank_we,
  input  wire logic             bank_wdata,
  input  wire cst_pkg::cst_ea_t ea_mode,
  input  wire logic [7:0]       ea_disp,
  output logic [15:0]           ea_addr_q,
  output logic [2:0]            bit_index_q,
  input  wire logic             sfr_we,
  input  wire logic [15:0]      sfr_addr,
  output logic [7:0]            sfr_rdata_q,
  output logic                  sfr_hit_q,
  output logic                  mem_req_q,
  output logic                  mem_we_q,
  output logic [15:0]           mem_addr_q,
  output logic [7:0]            mem_wdata_q,
  input  wire logic [7:0]       mem_rdata,
  output logic [15:0]           stack_pointer,
  output logic [15:0]           instruction_address_counter,
  output logic [7:0]            status_flag_word,
  output logic                  bank_select_field
);

  cst_pkg::cst_state_t state_q;
  cst_pkg::cst_op_t    kind_q;
  logic [15:0]         sp_q, pc_q, target_q;
  logic [7:0]          flags_q;
  logic                bank_q, vec_q;
  logic [1:0]          cnt_q;
  logic [2:0]          sel_q;
  logic [23:0]         push_buf_q, pop_buf_q;
  logic [5:0][15:0]    gpr;
  logic                cond_hit, accept;
  logic [15:0]         br_target, div_dividend, pop_word;
  logic [7:0]          div_c;
  logic [15:0]         div_quot, div_rem;
  logic                div_bad;
  logic                gpr_we;
  logic [2:0]          gpr_widx;
  logic [1:0]          gpr_wbe;
  logic [15:0]         gpr_wdata;

  function automatic logic [15:0] add_s8(input logic [15:0] base, input logic [7:0] d);
    add_s8 = base + {{8{d[7]}}, d};
  endfunction

  function automatic logic in_code(input logic [15:0] a);
    in_code = (a >= `CST_CODE_BASE) && (a <= `CST_CODE_LAST);
  endfunction

  function automatic logic [15:0] byte_sel(input logic [15:0] w, input logic hi);
    byte_sel = hi ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
  endfunction

  assign accept   = op_valid && op_ready;
  assign op_ready = (state_q == cst_pkg::CST_ST_IDLE);

  assign stack_pointer               = sp_q;
  assign instruction_address_counter = pc_q;
  assign status_flag_word            = flags_q;
  assign bank_select_field           = bank_q;

  cst_cond u_cond (
    .flags (flags_q),
    .cc    (op_cc),
    .hit   (cond_hit)
  );

  always_comb begin
    br_target = op_target;
    if (op_code == cst_pkg::CST_OP_JRS) begin
      br_target = add_s8(pc_q, {{3{op_disp[4]}}, op_disp[4:0]});
    end else if (op_code == cst_pkg::CST_OP_JR) begin
      br_target = add_s8(pc_q, op_disp);
    end
  end

  // divisor from C, result into chosen pair
  assign div_c        = gpr[1][7:0];
  assign div_dividend = gpr[op_sel[1:0]];
  assign div_quot     = (div_c == 8'h00) ? 16'hffff : div_dividend / {8'h00, div_c};
  assign div_rem      = (div_c == 8'h00) ? 16'h0000 : div_dividend % {8'h00, div_c};
  assign div_bad      = (div_c == 8'h00) || (div_quot[15:8] != 8'h00);

  // Three-byte frames hold flags in the top byte
  assign pop_word = (kind_q == cst_pkg::CST_OP_INTERRUPT_EXIT_INSN) ? pop_buf_q[15:0] : pop_buf_q[23:8];

  // byte and pair writes share one port
  always_comb begin
    gpr_we    = 1'b0;
    gpr_widx  = 3'h0;
    gpr_wbe   = 2'b11;
    gpr_wdata = reg_wdata;
    if (state_q == cst_pkg::CST_ST_DONE && kind_q == cst_pkg::CST_OP_POP) begin
      gpr_we    = (sel_q != `CST_IDX_SP);
      gpr_widx  = sel_q;
      gpr_wdata = pop_word;
    end else if (accept && op_code == cst_pkg::CST_OP_DIV && !div_bad) begin
      gpr_we    = 1'b1;
      gpr_widx  = {1'b0, op_sel[1:0]};
      gpr_wdata = {div_rem[7:0], div_quot[7:0]};
    end else if (reg_we && (reg_byte || reg_idx != `CST_IDX_SP)) begin
      gpr_we    = 1'b1;
      gpr_widx  = reg_byte ? {1'b0, reg_idx[2:1]} : reg_idx;
      gpr_wbe   = reg_byte ? (reg_idx[0] ? 2'b01 : 2'b10) : 2'b11;
      gpr_wdata = reg_byte ? {reg_wdata[7:0], reg_wdata[7:0]} : reg_wdata;
    end
  end

  cst_gpr u_gpr (
    .core_clk (core_clk),
    .rstn     (rstn),
    .bank     (bank_q),
    .we       (gpr_we),
    .widx     (gpr_widx),
    .wbe      (gpr_wbe),
    .wdata    (gpr_wdata),
    .rdata_q  (gpr)
  );

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q    <= cst_pkg::CST_ST_POP_RD;
      vec_q      <= 1'b1;
      cnt_q      <= 2'd2;
      kind_q     <= cst_pkg::CST_OP_NONE;
      sel_q      <= 3'h0;
      target_q   <= 16'h0000;
      push_buf_q <= 24'h000000;
      pop_buf_q  <= 24'h000000;
    end else begin
      unique case (state_q)
        cst_pkg::CST_ST_IDLE: begin
          if (accept) begin
            kind_q   <= op_code;
            sel_q    <= op_sel;
            target_q <= op_target;
            unique case (op_code)
              cst_pkg::CST_OP_CALL,
              cst_pkg::CST_OP_PUSH: begin
                push_buf_q <= {op_data, 8'h00};
                cnt_q      <= 2'd2;
                state_q    <= cst_pkg::CST_ST_PUSH;
              end
              // flag image ahead of return address
              cst_pkg::CST_OP_TRAP: begin
                push_buf_q <= {flags_q[7:2], 1'b0, bank_q, op_data};
                cnt_q      <= 2'd3;
                state_q    <= cst_pkg::CST_ST_PUSH;
              end
              cst_pkg::CST_OP_RET,
              cst_pkg::CST_OP_POP: begin
                cnt_q   <= 2'd2;
                state_q <= cst_pkg::CST_ST_POP_RD;
              end
              cst_pkg::CST_OP_INTERRUPT_EXIT_INSN: begin
                cnt_q   <= 2'd3;
                state_q <= cst_pkg::CST_ST_POP_RD;
              end
              default: state_q <= cst_pkg::CST_ST_IDLE;
            endcase
          end
        end
        cst_pkg::CST_ST_PUSH: begin
          push_buf_q <= {push_buf_q[15:0], 8'h00};
          cnt_q      <= cnt_q - 2'd1;
          if (cnt_q == 2'd1) begin
            state_q <= cst_pkg::CST_ST_DONE;
          end
        end
        cst_pkg::CST_ST_POP_RD:  state_q <= cst_pkg::CST_ST_POP_WT;
        cst_pkg::CST_ST_POP_WT:  state_q <= cst_pkg::CST_ST_POP_CAP;
        cst_pkg::CST_ST_POP_CAP: begin
          pop_buf_q <= {mem_rdata, pop_buf_q[23:8]};
          cnt_q     <= cnt_q - 2'd1;
          state_q   <= (cnt_q == 2'd1) ? cst_pkg::CST_ST_DONE : cst_pkg::CST_ST_POP_RD;
        end
        cst_pkg::CST_ST_DONE: begin
          vec_q   <= 1'b0;
          state_q <= cst_pkg::CST_ST_IDLE;
        end
        default: state_q <= cst_pkg::CST_ST_IDLE;
      endcase
    end
  end

  // post-decrement on push, pre-increment on pop
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mem_req_q   <= 1'b0;
      mem_we_q    <= 1'b0;
      mem_addr_q  <= 16'h0000;
      mem_wdata_q <= 8'h00;
    end else begin
      mem_req_q <= 1'b0;
      mem_we_q  <= 1'b0;
      if (state_q == cst_pkg::CST_ST_PUSH) begin
        mem_req_q   <= 1'b1;
        mem_we_q    <= 1'b1;
        mem_addr_q  <= sp_q;
        mem_wdata_q <= push_buf_q[23:16];
      end else if (state_q == cst_pkg::CST_ST_POP_RD) begin
        mem_req_q  <= 1'b1;
        mem_addr_q <= vec_q ? ((cnt_q == 2'd2) ? `CST_VEC_LO_ADDR : `CST_VEC_HI_ADDR) : sp_q + 16'h0001;
      end
    end
  end

  // full 16-bit pointer, anywhere in data space
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sp_q <= `CST_SP_RESET;
    end else if (state_q == cst_pkg::CST_ST_PUSH) begin
      sp_q <= sp_q - 16'h0001;
    end else if (state_q == cst_pkg::CST_ST_POP_RD && !vec_q) begin
      sp_q <= sp_q + 16'h0001;
    end else if (state_q == cst_pkg::CST_ST_DONE && kind_q == cst_pkg::CST_OP_POP && sel_q == `CST_IDX_SP) begin
      sp_q <= pop_word;
    end else if (reg_we && !reg_byte && reg_idx == `CST_IDX_SP) begin
      sp_q <= reg_wdata;
    end
  end

  // Program counter and branch outcome
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pc_q           <= `CST_PC_RESET;
      branch_taken_q <= 1'b0;
      branch_fault_q <= 1'b0;
      div_error_q    <= 1'b0;
      op_done_q      <= 1'b0;
    end else begin
      branch_taken_q <= 1'b0;
      branch_fault_q <= 1'b0;
      div_error_q    <= 1'b0;
      op_done_q      <= 1'b0;
      if (state_q == cst_pkg::CST_ST_DONE) begin
        op_done_q <= !vec_q;
        if (vec_q) begin
          pc_q <= pop_buf_q[23:8];
        end else if (kind_q == cst_pkg::CST_OP_RET || kind_q == cst_pkg::CST_OP_INTERRUPT_EXIT_INSN) begin
          pc_q <= pop_word;
        end else if (kind_q == cst_pkg::CST_OP_CALL || kind_q == cst_pkg::CST_OP_TRAP) begin
          if (in_code(target_q)) begin
            pc_q <= target_q;
          end else begin
            branch_fault_q <= 1'b1;
          end
        end
      end else if (accept) begin
        unique case (op_code)
          cst_pkg::CST_OP_STEP: begin
            pc_q      <= pc_q + {14'h0000, op_len};
            op_done_q <= 1'b1;
          end
          cst_pkg::CST_OP_JRS,
          cst_pkg::CST_OP_JR,
          cst_pkg::CST_OP_JP: begin
            op_done_q <= 1'b1;
            if (op_code == cst_pkg::CST_OP_JP || cond_hit) begin
              if (in_code(br_target)) begin
                pc_q           <= br_target;
                branch_taken_q <= 1'b1;
              end else begin
                branch_fault_q <= 1'b1;
              end
            end
          end
          cst_pkg::CST_OP_DIV: begin
            op_done_q   <= 1'b1;
            div_error_q <= div_bad;
          end
          cst_pkg::CST_OP_NONE: op_done_q <= 1'b1;
          default: op_done_q <= 1'b0;
        endcase
      end
    end
  end

  // cleared for determinism only, software must not rely on it
  // bits 1 and 0 always read zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flags_q <= 8'h00;
    end else if (state_q == cst_pkg::CST_ST_DONE && !vec_q && kind_q == cst_pkg::CST_OP_INTERRUPT_EXIT_INSN) begin
      flags_q <= pop_buf_q[23:16] & `CST_FLAG_MASK;
    end else if (accept && op_code == cst_pkg::CST_OP_DIV && div_bad) begin
      flags_q[`CST_BIT_CF] <= 1'b1;
    end else if (flag_we) begin
      flags_q <= flag_wdata & `CST_FLAG_MASK;
    end
  end

  // bank comes back with the flag word
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bank_q <= 1'b0;
    end else if (state_q == cst_pkg::CST_ST_DONE && !vec_q && kind_q == cst_pkg::CST_OP_INTERRUPT_EXIT_INSN) begin
      bank_q <= pop_buf_q[16 + `CST_BIT_BANK];
    end else if (bank_we) begin
      bank_q <= bank_wdata;
    end
  end

  // load to the flag address claimed but ignored
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata_q <= 8'h00;
      sfr_hit_q   <= 1'b0;
    end else begin
      sfr_rdata_q <= (sfr_addr == `CST_FLAG_ADDR) ? flags_q : 8'h00;
      sfr_hit_q   <= sfr_we && (sfr_addr == `CST_FLAG_ADDR);
    end
  end

  // A as offset and bit index
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ea_addr_q   <= 16'h0000;
      bit_index_q <= 3'h0;
    end else begin
      bit_index_q <= gpr[0][2:0];
      unique case (ea_mode)
        cst_pkg::CST_EA_DE:     ea_addr_q <= gpr[2];
        cst_pkg::CST_EA_HL:     ea_addr_q <= gpr[3];
        cst_pkg::CST_EA_IX:     ea_addr_q <= gpr[4];
        cst_pkg::CST_EA_IY:     ea_addr_q <= gpr[5];
        cst_pkg::CST_EA_IDX_HL: ea_addr_q <= add_s8(gpr[3], ea_disp);
        cst_pkg::CST_EA_IDX_IX: ea_addr_q <= add_s8(gpr[4], ea_disp);
        cst_pkg::CST_EA_IDX_IY: ea_addr_q <= add_s8(gpr[5], ea_disp);
        cst_pkg::CST_EA_IDX_SP: ea_addr_q <= add_s8(sp_q, ea_disp);
        cst_pkg::CST_EA_HL_C:   ea_addr_q <= gpr[3] + {8'h00, gpr[1][7:0]};
        cst_pkg::CST_EA_PC_A:   ea_addr_q <= pc_q + {8'h00, gpr[0][7:0]};
        default:                ea_addr_q <= 16'h0000;
      endcase
    end
  end

  // Register read port, stack pointer included
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_rd_byte) begin
      reg_rdata_q <= byte_sel(gpr[reg_rd_idx[2:1]], !reg_rd_idx[0]);
    end else if (reg_rd_idx == `CST_IDX_SP) begin
      reg_rdata_q <= sp_q;
    end else begin
      reg_rdata_q <= (reg_rd_idx < 3'h6) ? gpr[reg_rd_idx] : 16'h0000;
    end
  end

endmodule

`default_nettype wire

// ### hw/cst_defines.svh
// Constants for the core architectural state block
`ifndef CST_DEFINES_SVH
`define CST_DEFINES_SVH

`define CST_SP_RESET      16'h00ff
`define CST_PC_RESET      16'h0000
`define CST_VEC_LO_ADDR   16'hfffe
`define CST_VEC_HI_ADDR   16'hffff
`define CST_FLAG_ADDR     16'h003f
`define CST_CODE_BASE     16'hc000
`define CST_CODE_LAST     16'hffff
`define CST_BIT_JF        7
`define CST_BIT_ZF        6
`define CST_BIT_CF        5
`define CST_BIT_HF        4
`define CST_BIT_SF        3
`define CST_BIT_VF        2
`define CST_BIT_BANK      0
`define CST_FLAG_MASK     8'hfc
`define CST_GPR_WORDS     6
`define CST_IDX_SP        3'h6

`endif

// ### hw/cst_pkg.sv
// Types for the core architectural state block
`default_nettype none

package cst_pkg;

  typedef enum logic [3:0] {
    CST_OP_NONE, CST_OP_STEP, CST_OP_CALL, CST_OP_TRAP, CST_OP_RET, CST_OP_INTERRUPT_EXIT_INSN,
    CST_OP_PUSH, CST_OP_POP, CST_OP_JRS, CST_OP_JR, CST_OP_JP, CST_OP_DIV
  } cst_op_t;

  typedef enum logic [4:0] {
    CST_CC_T, CST_CC_F, CST_CC_Z, CST_CC_NZ, CST_CC_CS, CST_CC_CC, CST_CC_VS, CST_CC_VC,
    CST_CC_M, CST_CC_P, CST_CC_EQ, CST_CC_NE, CST_CC_LT, CST_CC_GE, CST_CC_LE, CST_CC_GT,
    CST_CC_SLT, CST_CC_SGE, CST_CC_SLE, CST_CC_SGT
  } cst_cc_t;

  typedef enum logic [3:0] {
    CST_EA_DE, CST_EA_HL, CST_EA_IX, CST_EA_IY, CST_EA_IDX_HL, CST_EA_IDX_IX,
    CST_EA_IDX_IY, CST_EA_IDX_SP, CST_EA_HL_C, CST_EA_PC_A
  } cst_ea_t;

  typedef enum logic [2:0] {
    CST_ST_IDLE, CST_ST_PUSH, CST_ST_POP_RD, CST_ST_POP_WT, CST_ST_POP_CAP, CST_ST_DONE
  } cst_state_t;

endpackage

`default_nettype wire

// ### hw/cst_cond.sv
// Branch condition evaluator over the flag word
`include "cst_defines.svh"
`default_nettype none

module cst_cond (
  input  wire logic [7:0]       flags,
  input  wire cst_pkg::cst_cc_t cc,
  output logic                  hit
);

  logic jf, zf, cf, sf, vf;

  assign jf = flags[`CST_BIT_JF];
  assign zf = flags[`CST_BIT_ZF];
  assign cf = flags[`CST_BIT_CF];
  assign sf = flags[`CST_BIT_SF];
  assign vf = flags[`CST_BIT_VF];

  // Half carry is never a condition
  always_comb begin
    hit = 1'b0;
    case (cc)
      cst_pkg::CST_CC_T:   hit = jf;
      cst_pkg::CST_CC_F:   hit = !jf;
      cst_pkg::CST_CC_Z,
      cst_pkg::CST_CC_EQ:  hit = zf;
      cst_pkg::CST_CC_NZ,
      cst_pkg::CST_CC_NE:  hit = !zf;
      cst_pkg::CST_CC_CS,
      cst_pkg::CST_CC_LT:  hit = cf;
      cst_pkg::CST_CC_CC,
      cst_pkg::CST_CC_GE:  hit = !cf;
      cst_pkg::CST_CC_VS:  hit = vf;
      cst_pkg::CST_CC_VC:  hit = !vf;
      cst_pkg::CST_CC_M:   hit = sf;
      cst_pkg::CST_CC_P:   hit = !sf;
      cst_pkg::CST_CC_LE:  hit = cf | zf;
      cst_pkg::CST_CC_GT:  hit = !(cf | zf);
      cst_pkg::CST_CC_SLT: hit = sf ^ vf;
      cst_pkg::CST_CC_SGE: hit = !(sf ^ vf);
      cst_pkg::CST_CC_SLE: hit = zf | (sf ^ vf);
      cst_pkg::CST_CC_SGT: hit = !(zf | (sf ^ vf));
      default:             hit = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// ### hw/cst_gpr.sv
// Two-bank storage for the pairs and index registers
`include "cst_defines.svh"
`default_nettype none

module cst_gpr (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              bank,
  input  wire logic              we,
  input  wire logic [2:0]        widx,
  input  wire logic [1:0]        wbe,
  input  wire logic [15:0]       wdata,
  output logic      [5:0][15:0]  rdata_q
);

  logic [15:0] mem_q [2*`CST_GPR_WORDS];

  function automatic logic [3:0] slot(input logic b, input logic [2:0] i);
    slot = b ? 4'(i) + 4'(`CST_GPR_WORDS) : 4'(i);
  endfunction

  // No reset: contents are left undefined on purpose
  always_ff @(posedge core_clk) begin
    if (we && wbe[1]) begin
      mem_q[slot(bank, widx)][15:8] <= wdata[15:8];
    end
    if (we && wbe[0]) begin
      mem_q[slot(bank, widx)][7:0] <= wdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= '0;
    end else begin
      for (int k = 0; k < `CST_GPR_WORDS; k++) begin
        rdata_q[k] <= mem_q[slot(bank, 3'(k))];
      end
    end
  end

endmodule

`default_nettype wire

// ### test/cst_core_state_asserts.sv
// Port checker for the core state block
`default_nettype none
module cst_core_state_asserts (
  input wire logic             core_clk,
  input wire logic             rstn,
  input wire logic             op_valid,
  input wire logic             op_ready,
  input wire cst_pkg::cst_op_t op_code,
  input wire logic [7:0]       op_disp,
  input wire logic [15:0]      op_data,
  input wire logic [15:0]      op_target,
  input wire logic             branch_taken_q,
  input wire logic             branch_fault_q,
  input wire logic             mem_req_q,
  input wire logic             mem_we_q,
  input wire logic [15:0]      mem_addr_q,
  input wire logic [7:0]       mem_wdata_q,
  input wire logic [15:0]      stack_pointer,
  input wire logic [15:0]      instruction_address_counter,
  input wire logic [7:0]       status_flag_word,
  input wire logic             bank_select_field
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  wire logic [15:0] pc = instruction_address_counter;
  wire logic        go = op_valid && op_ready;
  wire logic        call = go && op_code == cst_pkg::CST_OP_CALL;
  wire logic        jp = go && op_code == cst_pkg::CST_OP_JP;
  wire logic [7:0]  hi = op_data[15:8];
  wire logic [7:0]  lo = op_data[7:0];
  // Bit 0 of the stacked image carries the bank, bit 1 is zero
  wire logic [7:0]  img = {status_flag_word[7:2], 1'h0, bank_select_field};
  wire logic [15:0] jr_t = pc + {{8{op_disp[7]}}, op_disp};
  AST_RST_SP: assert property ($rose(rstn) |-> stack_pointer == 16'h00ff)
    else $error("stack pointer not at default");
  AST_RST_VEC: assert property ($rose(rstn) |-> ##[0:2] (mem_req_q && mem_addr_q == 16'hfffe))
    else $error("vector low byte not fetched");
  AST_CALL_BYTES: assert property (call |-> ##2 mem_we_q && mem_wdata_q == $past(hi, 2)
    ##1 mem_we_q && mem_wdata_q == $past(lo, 3)) else $error("call push order wrong");
  AST_CALL_SP: assert property (call |-> ##3 stack_pointer == $past(stack_pointer, 3) - 16'h0002)
    else $error("stack pointer not decremented");
  AST_TRAP_IMG: assert property (go && op_code == cst_pkg::CST_OP_TRAP |-> ##2
    mem_addr_q == $past(stack_pointer, 2) && mem_wdata_q == $past(img, 2)) else $error("flag image not first");
  AST_JP_LOAD: assert property (jp && op_target >= 16'hc000 |=> branch_taken_q && pc == $past(op_target))
    else $error("absolute target not loaded");
  AST_JP_FAULT: assert property (jp && op_target < 16'hc000 |=> branch_fault_q && $stable(pc))
    else $error("data area target taken");
  AST_JR_TGT: assert property (go && op_code == cst_pkg::CST_OP_JR |=> !branch_taken_q || pc == $past(jr_t))
    else $error("relative target wrong");
  cover property (call);
  cover property (jp && op_target < 16'hc000);
  cover property (go && op_code == cst_pkg::CST_OP_INTERRUPT_EXIT_INSN);
endmodule
bind cst_core_state cst_core_state_asserts u_chk (.*);
`default_nettype wire

// ### test/cst_core_state_test.sv
// Directed bench for the core state block
`default_nettype none
module cst_core_state_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'h0, rstn = 1'h0, op_valid = 1'h0, reg_we = 1'h0, reg_byte = 1'h0, reg_rd_byte = 1'h0;
  logic flag_we = 1'h0, bank_we = 1'h0, bank_wdata = 1'h0, sfr_we = 1'h0;
  cst_pkg::cst_op_t op_code = cst_pkg::CST_OP_NONE;
  cst_pkg::cst_cc_t op_cc = cst_pkg::CST_CC_T;
  cst_pkg::cst_ea_t ea_mode = cst_pkg::CST_EA_IDX_HL;
  logic [7:0] op_disp = 8'h00, flag_wdata = 8'h00, ea_disp = 8'hfe, mem_rdata = 8'h00;
  logic [15:0] op_data = 16'h0000, op_target = 16'h0000, reg_wdata = 16'h0000, sfr_addr = 16'h003f;
  logic [2:0] op_sel = 3'h0, reg_idx = 3'h0, reg_rd_idx = 3'h0, bit_index_q;
  logic [1:0] op_len = 2'h2;
  logic op_ready, op_done_q, branch_taken_q, branch_fault_q, div_error_q, sfr_hit_q, mem_req_q, mem_we_q;
  logic bank_select_field;
  logic [15:0] reg_rdata_q, ea_addr_q, mem_addr_q, stack_pointer, instruction_address_counter;
  logic [7:0] sfr_rdata_q, mem_wdata_q, status_flag_word, mem [logic [15:0]];
  int fail_count = 0, compares = 0, n = 0;
  wire logic [15:0] pc = instruction_address_counter;
  cst_core_state dut (.*);
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // Idle read data toggles so a late capture cannot pass
  always @(posedge core_clk) begin
    if (mem_req_q && !mem_we_q) mem_rdata <= #1 mem[mem_addr_q];
    else mem_rdata <= #1 ~mem_rdata;
    if (mem_req_q && mem_we_q) mem[mem_addr_q] = mem_wdata_q;
  end
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic op(cst_pkg::cst_op_t c, cst_pkg::cst_cc_t cc = cst_pkg::CST_CC_T, logic [7:0] dp = 8'h00,
                    logic [15:0] t = 16'h0000, logic [15:0] d = 16'h0000);
    op_code = c;
    op_cc = cc;
    op_disp = dp;
    op_target = t;
    op_data = d;
    op_valid = 1'h1;
    @(posedge core_clk);
    #1 op_valid = 1'h0;
    n = 0;
    while (op_done_q !== 1'h1 && n < 20) begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask
  task automatic wr(logic b, logic [2:0] i, logic [15:0] d);
    reg_byte = b;
    reg_idx = i;
    reg_wdata = d;
    reg_we = 1'h1;
    @(posedge core_clk);
    #1 reg_we = 1'h0;
  endtask
  task automatic rd(logic b, logic [2:0] i, logic [15:0] e);
    reg_rd_byte = b;
    reg_rd_idx = i;
    repeat (2) @(posedge core_clk);
    #1 chk("reg", e, reg_rdata_q);
  endtask
  task automatic setf(logic [7:0] f, logic b);
    flag_wdata = f;
    bank_wdata = b;
    flag_we = 1'h1;
    bank_we = 1'h1;
    @(posedge core_clk);
    #1 flag_we = 1'h0;
    bank_we = 1'h0;
  endtask
  task automatic br(cst_pkg::cst_op_t c, cst_pkg::cst_cc_t cc, logic [7:0] dp, logic [15:0] t, logic [15:0] e);
    op(c, cc, dp, t);
    chk("branch pc", e, pc);
  endtask
  task automatic t_call_ret;
    op(cst_pkg::CST_OP_CALL, cst_pkg::CST_CC_T, 8'h00, 16'hc400, 16'hc123);
    chk("call lat", 16'h0003, 16'(n));
    chk("push hi", 16'h00c1, {8'h00, mem[16'h00ff]});
    chk("push lo", 16'h0023, {8'h00, mem[16'h00fe]});
    chk("call sp", 16'h00fd, stack_pointer);
    op(cst_pkg::CST_OP_RET);
    chk("ret lat", 16'h0007, 16'(n));
    chk("ret pc", 16'hc123, pc);
    chk("ret sp", 16'h00ff, stack_pointer);
  endtask
  task automatic t_trap_interrupt_exit_insn;
    setf(8'ha4, 1'h1);
    op(cst_pkg::CST_OP_TRAP, cst_pkg::CST_CC_T, 8'h00, 16'hc800, 16'hc200);
    chk("trap img", 16'h00a5, {8'h00, mem[16'h00ff]});
    chk("trap hi", 16'h00c2, {8'h00, mem[16'h00fe]});
    chk("trap sp", 16'h00fc, stack_pointer);
    setf(8'h00, 1'h0);
    op(cst_pkg::CST_OP_INTERRUPT_EXIT_INSN);
    chk("interrupt_exit_insn lat", 16'h000a, 16'(n));
    chk("interrupt_exit_insn pc", 16'hc200, pc);
    chk("interrupt_exit_insn flags", 16'h00a4, {8'h00, status_flag_word});
    chk("interrupt_exit_insn bank", 16'h0001, {15'h0000, bank_select_field});
  endtask
  task automatic t_branch;
    br(cst_pkg::CST_OP_JP, cst_pkg::CST_CC_F, 8'h00, 16'hc235, 16'hc235);
    br(cst_pkg::CST_OP_JP, cst_pkg::CST_CC_T, 8'h00, 16'h1000, 16'hc235);
    br(cst_pkg::CST_OP_JR, cst_pkg::CST_CC_T, 8'h80, 16'h0000, 16'hc1b5);
    br(cst_pkg::CST_OP_JRS, cst_pkg::CST_CC_T, 8'h08, 16'h0000, 16'hc1bd);
    br(cst_pkg::CST_OP_JR, cst_pkg::CST_CC_Z, 8'h10, 16'h0000, 16'hc1bd);
    br(cst_pkg::CST_OP_JR, cst_pkg::CST_CC_F, 8'h10, 16'h0000, 16'hc1bd);
    setf(8'h40, 1'h1);
    br(cst_pkg::CST_OP_JR, cst_pkg::CST_CC_Z, 8'h10, 16'h0000, 16'hc1cd);
    br(cst_pkg::CST_OP_JRS, cst_pkg::CST_CC_F, 8'h1f, 16'h0000, 16'hc1cc);
    br(cst_pkg::CST_OP_STEP, cst_pkg::CST_CC_T, 8'h00, 16'h0000, 16'hc1ce);
  endtask
  task automatic t_sfr;
    sfr_we = 1'h1;
    @(posedge core_clk);
    #1 sfr_we = 1'h0;
    chk("sfr hit", 16'h0001, {15'h0000, sfr_hit_q});
    @(posedge core_clk);
    #1 chk("flags kept", 16'h0040, {8'h00, status_flag_word});
    chk("flag read", 16'h0040, {8'h00, sfr_rdata_q});
  endtask
  task automatic t_regs;
    wr(1'h0, 3'h0, 16'h0107);
    wr(1'h0, 3'h1, 16'h0010);
    // Register reads lag a write by two edges
    @(posedge core_clk);
    #1 op(cst_pkg::CST_OP_DIV);
    rd(1'h0, 3'h0, 16'h0710);
    rd(1'h1, 3'h1, 16'h0010);
    setf(8'h40, 1'h0);
    wr(1'h0, 3'h0, 16'h5555);
    setf(8'h40, 1'h1);
    rd(1'h0, 3'h0, 16'h0710);
    wr(1'h0, 3'h3, 16'h2468);
    rd(1'h0, 3'h3, 16'h2468);
    chk("ea", 16'h2466, ea_addr_q);
    wr(1'h0, 3'h6, 16'h0123);
    chk("sp write", 16'h0123, stack_pointer);
  endtask
  task automatic wrap_up;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    mem[16'hfffe] = 8'h00;
    mem[16'hffff] = 8'hc1;
    repeat (12) @(posedge core_clk);
    #1 rstn = 1'h1;
    repeat (10) @(posedge core_clk);
    #1 chk("vector", 16'hc100, pc);
    chk("reset sp", 16'h00ff, stack_pointer);
    t_call_ret;
    t_trap_interrupt_exit_insn;
    t_branch;
    t_sfr;
    t_regs;
    wrap_up;
  end
  // Tests need well under 200 cycles
  initial begin
    #100000;
    fail_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
